// ### pkg/exception_lowpower_reset_status_map.svh
// constants for the exception, low-power and reset-status block
// assumes inclusion by bare name from the design file
`ifndef EXCEPTION_LOWPOWER_RESET_STATUS_MAP_SVH
`define EXCEPTION_LOWPOWER_RESET_STATUS_MAP_SVH

// register indices on the plain register port
`define BREAK_EXIT_STATUS_OFS 2'h0
`define RESET_SOURCE_STATUS_OFS 2'h1
`define BREAK_FLAG_CLEAR_CONTROL_OFS 2'h2

// field positions
`define BREAK_WAIT_EXIT_FLAG_BIT 0
`define BREAK_FLAG_CLEAR_ENABLE_BIT 7
`define RSR_POWER_ON_BIT 7
`define RSR_SOURCES_LSB 1

// reset values
`define BREAK_EXIT_STATUS_RST 8'h00
`define RESET_SOURCE_STATUS_RST 8'h80
`define BREAK_FLAG_CLEAR_CONTROL_RST 8'h00

// stop recovery in oscillator clock cycles
`define STOP_RECOVERY_OSC_CYCLES 4096
// bus clock cycles per oscillator clock cycle
`define OSC_DIVIDE 1

`endif

// ### pkg/exception_lowpower_reset_status_pkg.sv
// types for the exception, low-power and reset-status block
// assumes the map header sits on the include path
package exception_lowpower_reset_status_pkg;

  // sequencer states, one-hot
  typedef enum logic [4:0] {
    st_run = 5'h01,
    st_wait = 5'h02,
    st_stop = 5'h04,
    st_recover = 5'h08,
    st_stack = 5'h10
  } seq_state_type;

  // one flag per reset source, same order as in the status register
  typedef struct packed {
    logic ext_pin;
    logic watchdog;
    logic bad_opcode;
    logic bad_fetch_address;
    logic forced_monitor_entry;
    logic low_voltage;
  } rst_src_type;

  // clock gating group towards the clock generator
  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic bus_out_en;
    logic osc_en;
  } clk_ctl_type;

endpackage

// ### verilog/exception_lowpower_reset_status.sv
// interrupt sequencing, wait and stop control, reset-source status
// assumes cpu, interrupt sources and reset sources share clk
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "exception_lowpower_reset_status_map.svh"

module exception_lowpower_reset_status
  import exception_lowpower_reset_status_pkg::*;
#(
  parameter int NUM_IRQ = 8,
  parameter int STOP_RECOVERY_CYC = `STOP_RECOVERY_OSC_CYCLES,
  parameter int OSC_DIV = `OSC_DIVIDE
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic instr_done,
  input wire logic cpu_i_mask,
  input wire logic software_interrupt_instruction,
  input wire logic wait_exec,
  input wire logic stop_exec,
  input wire logic [NUM_IRQ-1:0] irq_req,
  input wire logic [NUM_IRQ-1:0] irq_en,
  input wire logic break_req,
  input wire logic break_state,
  input wire logic watchdog_disable_cfg,
  input wire logic ext_rst_pin_n,
  input wire logic watchdog_rst,
  input wire logic bad_opcode_rst,
  input wire logic opcode_fetch,
  input wire logic fetch_unmapped,
  input wire logic monitor_entry_rst,
  input wire logic low_voltage_rst,
  output logic int_start,
  output logic [$clog2(NUM_IRQ+1)-1:0] int_vector,
  output logic stack_high_index,
  output logic i_mask_clear,
  output clk_ctl_type clk_ctl,
  output logic sys_counter_clear,
  output logic watchdog_run,
  output logic system_reset
);

  localparam int VW = $clog2(NUM_IRQ+1);
  localparam int RW = $clog2(STOP_RECOVERY_CYC+1);
  localparam int DW = $clog2(OSC_DIV+1);
  localparam logic [VW-1:0] SWI_VEC = VW'(NUM_IRQ);
  localparam logic [RW-1:0] REC_LAST = RW'(STOP_RECOVERY_CYC - 1);
  localparam logic [DW-1:0] DIV_LAST = DW'(OSC_DIV - 1);

  seq_state_type state_q;
  seq_state_type state_d;
  logic [VW-1:0] vec_q;
  logic [VW-1:0] vec_d;
  logic [RW-1:0] rec_cnt_q;
  logic [DW-1:0] div_q;
  logic osc_tick;
  logic [2:0] pin_sync_q;
  logic pin_low_q;
  rst_src_type src;
  logic any_rst;
  logic [NUM_IRQ-1:0] pend;
  logic pend_any;
  logic take_int;
  logic [7:0] bes_q;
  logic [7:0] rsr_q;
  logic [7:0] bfc_q;
  logic clear_ok;
  logic rsr_rd;
  logic bes_wr;
  logic brk_wake_q;
  logic cpu_gate_q;
  logic was_wait_q;

  // lowest index wins; returns NUM_IRQ when nothing pends
  function automatic logic [VW-1:0] prio_sel(input logic [NUM_IRQ-1:0] p);
    logic [VW-1:0] r;
    r = SWI_VEC;
    for (int i = NUM_IRQ - 1; i >= 0; i--)
    begin
      if (p[i])
      begin
        r = VW'(i);
      end
    end
    return r;
  endfunction

  // register index decode, used by reads and writes
  function automatic logic hit(input logic [1:0] a, input logic [1:0] ofs);
    return a == ofs;
  endfunction

  // pin passes three flops; level moves once the last two agree
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      pin_sync_q <= 3'h7;
      pin_low_q <= 1'b0;
    end
    else
    begin
      pin_sync_q <= {pin_sync_q[1:0], ext_rst_pin_n};
      if (pin_sync_q[2] == pin_sync_q[1])
      begin
        pin_low_q <= ~pin_sync_q[2];
      end
    end
  end

  assign src.bad_fetch_address = opcode_fetch & fetch_unmapped;
  assign src.ext_pin = pin_low_q;
  assign src.watchdog = watchdog_rst;
  assign src.bad_opcode = bad_opcode_rst;
  assign src.forced_monitor_entry = monitor_entry_rst;
  assign src.low_voltage = low_voltage_rst;
  assign any_rst = |src;

  // request qualification, enable bit per source
  assign pend = irq_req & irq_en;
  assign pend_any = |pend;
  // mask and enable gate entry; swi bypasses mask
  assign take_int = software_interrupt_instruction |
                    (pend_any & ~cpu_i_mask);

  // oscillator-rate enable pulse from a divider
  always_ff @(posedge clk)
  begin
    if (!nrst || div_q == DIV_LAST)
    begin
      div_q <= '0;
    end
    else
    begin
      div_q <= div_q + DW'(1);
    end
  end
  assign osc_tick = (div_q == DIV_LAST);

  // sequencer next state; reset sources override everything
  always_comb
  begin
    state_d = state_q;
    vec_d = vec_q;
    case (state_q)
      st_run:
      begin
        if (instr_done)
        begin
          if (wait_exec)
          begin
            state_d = st_wait;
          end
          else if (stop_exec)
          begin
            state_d = st_stop;
          end
          else if (take_int)
          begin
            state_d = st_stack;
            vec_d = software_interrupt_instruction ? SWI_VEC :
                    prio_sel(pend);
          end
        end
      end
      st_wait:
      begin
        if (break_req)
        begin
          state_d = st_stack;
          vec_d = SWI_VEC;
        end
        else if (pend_any)
        begin
          state_d = st_stack;
          vec_d = prio_sel(pend);
        end
      end
      st_stop:
      begin
        if (pend_any || break_req)
        begin
          state_d = st_recover;
          vec_d = break_req ? SWI_VEC : prio_sel(pend);
        end
      end
      st_recover:
      begin
        // stack only after the full delay
        if (osc_tick && rec_cnt_q == REC_LAST)
        begin
          state_d = st_stack;
        end
      end
      st_stack:
      begin
        state_d = st_run;
      end
      default:
      begin
        state_d = st_run;
      end
    endcase
    if (any_rst)
    begin
      state_d = st_run;
    end
  end

  // sequencer state and latched vector
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_q <= st_run;
      vec_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      vec_q <= vec_d;
    end
  end

  // stop recovery counter, oscillator rate
  always_ff @(posedge clk)
  begin
    if (!nrst || state_q != st_recover)
    begin
      rec_cnt_q <= '0;
    end
    else if (osc_tick && rec_cnt_q != REC_LAST)
    begin
      rec_cnt_q <= rec_cnt_q + RW'(1);
    end
  end

  // remember a break wake-up from wait for the status flag
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      brk_wake_q <= 1'b0;
    end
    else
    begin
      brk_wake_q <= state_q == st_wait && break_req && !any_rst;
    end
  end

  // previous-cycle wait marker, turns the mask clear into one pulse
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      was_wait_q <= 1'b0;
    end
    else
    begin
      was_wait_q <= state_q == st_wait;
    end
  end

  // cpu clock gate; registered so the output is a flop
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cpu_gate_q <= 1'b1;
    end
    else
    begin
      cpu_gate_q <= state_d == st_run || state_d == st_stack;
    end
  end

  // cpu gated in wait, peripherals kept; stop halts all
  assign clk_ctl.cpu_clk_en = cpu_gate_q;
  assign clk_ctl.periph_clk_en = state_q != st_stop;
  assign clk_ctl.bus_out_en = state_q != st_stop;
  assign clk_ctl.osc_en = state_q != st_stop;
  // system counter held clear while stopped
  assign sys_counter_clear = state_q == st_stop;
  // watchdog keeps counting in wait unless disabled
  assign watchdog_run = ~watchdog_disable_cfg & (state_q != st_stop);
  // mask cleared as wait is entered
  assign i_mask_clear = state_q == st_wait && !was_wait_q;
  assign int_start = state_q == st_stack;
  assign int_vector = vec_q;
  // high index byte is not part of the stack frame
  assign stack_high_index = 1'b0;
  // any source resets, ahead of interrupts
  assign system_reset = any_rst;

  // status clearing allowed outside break or when enabled
  // break clear gating
  assign clear_ok = ~break_state | bfc_q[`BREAK_FLAG_CLEAR_ENABLE_BIT];
  assign rsr_rd = reg_rd & hit(reg_addr, `RESET_SOURCE_STATUS_OFS);
  assign bes_wr = reg_wr & hit(reg_addr, `BREAK_EXIT_STATUS_OFS) &
                  ~reg_wdata[`BREAK_WAIT_EXIT_FLAG_BIT];

  // break exit flag; set wins over a write of zero
  always_ff @(posedge clk)
  begin
    if (!nrst || any_rst)
    begin
      bes_q <= `BREAK_EXIT_STATUS_RST;
    end
    // set by break wake, cleared by zero write
    else if (brk_wake_q)
    begin
      bes_q[`BREAK_WAIT_EXIT_FLAG_BIT] <= 1'b1;
    end
    else if (bes_wr && clear_ok)
    begin
      bes_q[`BREAK_WAIT_EXIT_FLAG_BIT] <= 1'b0;
    end
  end

  // reset source flags; a new reset beats a clearing read
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      rsr_q <= `RESET_SOURCE_STATUS_RST;
    end
    else if (any_rst)
    begin
      rsr_q <= {1'b0, src, 1'b0};
    end
    else if (rsr_rd && clear_ok)
    begin
      rsr_q <= 8'h00;
    end
  end

  // break flag clear control, plain read/write
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      bfc_q <= `BREAK_FLAG_CLEAR_CONTROL_RST;
    end
    else if (reg_wr && hit(reg_addr, `BREAK_FLAG_CLEAR_CONTROL_OFS))
    begin
      bfc_q[`BREAK_FLAG_CLEAR_ENABLE_BIT] <=
        reg_wdata[`BREAK_FLAG_CLEAR_ENABLE_BIT];
    end
  end

  // eight-bit read data, one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!nrst || !reg_rd)
    begin
      reg_rdata <= 8'h00;
    end
    else if (hit(reg_addr, `BREAK_EXIT_STATUS_OFS))
    begin
      reg_rdata <= bes_q;
    end
    else if (hit(reg_addr, `RESET_SOURCE_STATUS_OFS))
    begin
      reg_rdata <= rsr_q;
    end
    else if (hit(reg_addr, `BREAK_FLAG_CLEAR_CONTROL_OFS))
    begin
      reg_rdata <= bfc_q;
    end
    else
    begin
      reg_rdata <= 8'h00;
    end
  end

  a_entry_at_end: assert property (@(posedge clk) disable iff (!nrst)
    state_q == st_run && !instr_done |=> state_q != st_stack)
    else $error("entry without instruction end");

  a_mask_blocks: assert property (@(posedge clk) disable iff (!nrst)
    state_q == st_run && instr_done && cpu_i_mask && !wait_exec &&
    !stop_exec && !software_interrupt_instruction && !any_rst
    |=> state_q == st_run)
    else $error("masked request taken");

  // latched vector is the top pending request
  a_prio_pick: assert property (@(posedge clk) disable iff (!nrst)
    state_q == st_run && instr_done && !wait_exec && !stop_exec &&
    !software_interrupt_instruction && pend_any && !cpu_i_mask &&
    !any_rst |=> int_start && int_vector == prio_sel($past(pend)))
    else $error("wrong priority vector");

  a_swi_enters: assert property (@(posedge clk) disable iff (!nrst)
    state_q == st_run && instr_done && software_interrupt_instruction &&
    !wait_exec && !stop_exec && !any_rst
    |=> int_start && int_vector == SWI_VEC)
    else $error("swi not taken");

  a_wait_clocks: assert property (@(posedge clk) disable iff (!nrst)
    state_q == st_wait && $past(state_q) == st_wait
    |-> !clk_ctl.cpu_clk_en && clk_ctl.periph_clk_en)
    else $error("wait clock gating wrong");

  a_wait_wake: assert property (@(posedge clk) disable iff (!nrst)
    state_q == st_wait && pend_any && !any_rst |=> int_start)
    else $error("late wake from wait");

  a_stop_off: assert property (@(posedge clk) disable iff (!nrst)
    state_q == st_stop |-> !clk_ctl.bus_out_en && !clk_ctl.osc_en &&
    !clk_ctl.periph_clk_en && sys_counter_clear)
    else $error("stop left clocks on");

  // no stacking before recovery count done
  a_recover_hold: assert property (@(posedge clk) disable iff (!nrst)
    state_q == st_recover && rec_cnt_q != REC_LAST |=> !int_start)
    else $error("stack before stop recovery");

  a_read_clear: assert property (@(posedge clk) disable iff (!nrst)
    rsr_rd && clear_ok && !any_rst |=> rsr_q == 8'h00 ##1
    ($past(any_rst) || rsr_q == 8'h00))
    else $error("reset status not cleared");

  // flags hold in break without enable
  a_break_hold: assert property (@(posedge clk) disable iff (!nrst)
    rsr_rd && !clear_ok && !any_rst |=> $stable(rsr_q))
    else $error("flags cleared in break");

  // fetch fault flag needs an opcode fetch
  a_fetch_only: assert property (@(posedge clk) disable iff (!nrst)
    $rose(rsr_q[`RSR_SOURCES_LSB + 2]) |-> $past(opcode_fetch))
    else $error("address flag without fetch");

  // break wake sets the exit flag two cycles on
  a_break_flag: assert property (@(posedge clk) disable iff (!nrst)
    state_q == st_wait && break_req && !any_rst ##1 !any_rst
    |=> bes_q[`BREAK_WAIT_EXIT_FLAG_BIT])
    else $error("break exit flag not set");

  // wait entry pulses the mask clear and stops the cpu clock
  a_wait_mask: assert property (@(posedge clk) disable iff (!nrst)
    state_q == st_run && instr_done && wait_exec && !any_rst
    |=> i_mask_clear && !clk_ctl.cpu_clk_en)
    else $error("wait entry did not clear mask");

endmodule

// ### bench/cpu_irq_model.sv
// cpu core and peripheral request sources facing the block
// assumes the bench issues instructions and request pulses on clk
`timescale 1ns/1ps
module cpu_irq_model
  import exception_lowpower_reset_status_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic issue,
  input wire logic [1:0] kind,
  input wire logic [7:0] set_irq,
  input wire logic clr,
  input wire logic cpu_clk_en,
  input wire logic int_start,
  input wire logic [3:0] int_vector,
  output logic instr_done,
  output logic sw_intr,
  output logic wait_exec,
  output logic stop_exec,
  output logic [7:0] irq_q
);
  // a halted core never completes an instruction
  assign instr_done = issue & cpu_clk_en;
  assign sw_intr = kind == 2'h1;
  assign wait_exec = kind == 2'h2;
  assign stop_exec = kind == 2'h3;

  // requests stay latched until their entry is taken or clr flushes them
  always_ff @(posedge clk)
  begin
    if (!nrst || clr)
    begin
      irq_q <= 8'h00;
    end
    else
    begin
      irq_q <= irq_q | set_irq;
      if (int_start && int_vector < 4'h8)
      begin
        irq_q[int_vector[2:0]] <= 1'b0;
      end
    end
  end
endmodule

// ### bench/exception_lowpower_reset_status_test.sv
// self-checking bench for interrupt, low-power and reset status
// assumes the design, its package and the cpu model are compiled first
`timescale 1ns/1ps
module exception_lowpower_reset_status_test
  import exception_lowpower_reset_status_pkg::*;
;
  localparam int STOP_REC = 8;
  logic clk, nrst, reg_wr, reg_rd, cpu_i_mask, break_req, break_state;
  logic wdis, issue, clr, unm_only, rd_seen, instr_done, sw_intr;
  logic wait_exec, stop_exec, int_start, stack_high_index, i_mask_clear;
  logic sys_counter_clear, watchdog_run, system_reset;
  logic [1:0] reg_addr, kind;
  logic [7:0] reg_wdata, reg_rdata, set_irq, irq_en, irq_q, pend, en;
  logic [5:0] rsrc;
  logic [3:0] int_vector, v;
  clk_ctl_type clk_ctl;
  int errors, checked, cycles, seed, n;
  logic [7:0] exp_rd[$];
  logic [3:0] exp_vec[$];

  exception_lowpower_reset_status #(.STOP_RECOVERY_CYC(STOP_REC))
    exception_lowpower_reset_status_inst (.clk(clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .instr_done(instr_done),
    .cpu_i_mask(cpu_i_mask), .software_interrupt_instruction(sw_intr),
    .wait_exec(wait_exec), .stop_exec(stop_exec), .irq_req(irq_q),
    .irq_en(irq_en), .break_req(break_req), .break_state(break_state),
    .watchdog_disable_cfg(wdis), .ext_rst_pin_n(!rsrc[0]),
    .watchdog_rst(rsrc[1]), .bad_opcode_rst(rsrc[2]),
    .opcode_fetch(rsrc[3]), .fetch_unmapped(rsrc[3] | unm_only),
    .monitor_entry_rst(rsrc[4]), .low_voltage_rst(rsrc[5]),
    .int_start(int_start), .int_vector(int_vector),
    .stack_high_index(stack_high_index), .i_mask_clear(i_mask_clear),
    .clk_ctl(clk_ctl), .sys_counter_clear(sys_counter_clear),
    .watchdog_run(watchdog_run), .system_reset(system_reset));

  cpu_irq_model cpu_irq_model_inst (.clk(clk), .nrst(nrst),
    .issue(issue), .kind(kind), .set_irq(set_irq), .clr(clr),
    .cpu_clk_en(clk_ctl.cpu_clk_en), .int_start(int_start),
    .int_vector(int_vector), .instr_done(instr_done), .sw_intr(sw_intr),
    .wait_exec(wait_exec), .stop_exec(stop_exec), .irq_q(irq_q));

  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    errors += exp_rd.size() + exp_vec.size();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // expected data is queued before the strobe goes out
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    exp_rd.push_back(e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  task automatic instr(input logic [1:0] k);
    @(posedge clk);
    kind <= k;
    issue <= 1'b1;
    @(posedge clk);
    issue <= 1'b0;
    #1;
  endtask

  task automatic irq(input logic [7:0] b);
    @(posedge clk);
    set_irq <= b;
    @(posedge clk);
    set_irq <= 8'h00;
  endtask

  task automatic flush();
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask

  // bounded wait for an entry cycle, k counts the cycles taken
  task automatic wait_int(output int k);
    k = 0;
    while (int_start !== 1'b1 && k < 200)
    begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask

  function automatic logic [3:0] lowest(input logic [7:0] p);
    lowest = 4'h8;
    for (int i = 7; i >= 0; i--)
      if (p[i])
        lowest = 4'(i);
  endfunction

  // watcher: every read answer and entry takes the oldest note
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      print_verdict();
    end
    else
    begin
      if (rd_seen)
      begin
        if (exp_rd.size() == 0)
          check(reg_rdata, 8'hXX);
        else
          check(reg_rdata, exp_rd.pop_front());
      end
      rd_seen <= reg_rd;
      if (nrst && int_start === 1'b1)
      begin
        if (exp_vec.size() == 0)
          check({4'h0, int_vector}, 8'hXX);
        else
          check({4'h0, int_vector}, {4'h0, exp_vec.pop_front()});
      end
    end
  end

  initial
  begin
    {nrst, reg_wr, reg_rd, cpu_i_mask, break_req, break_state} = '0;
    {wdis, issue, clr, unm_only, rd_seen} = '0;
    {reg_addr, kind, reg_wdata, set_irq, rsrc} = '0;
    irq_en = 8'hFF;
    errors = 0;
    checked = 0;
    cycles = 0;
    seed = 60;
    cyc(20);
    nrst <= 1'b1;
    rd(2'h0, 8'h00);
    rd(2'h1, 8'h80);
    rd(2'h2, 8'h00);
    rd(2'h3, 8'h00);
    rd(2'h1, 8'h00);
    // two pending, lower index first, then the other on return
    exp_vec.push_back(4'h2);
    exp_vec.push_back(4'h5);
    irq(8'h24);
    instr(2'h0);
    cyc(3);
    instr(2'h0);
    cyc(3);
    // pending with no completed instruction must wait
    irq(8'h02);
    cyc(4);
    cpu_i_mask <= 1'b1;
    instr(2'h0);
    cyc(3);
    exp_vec.push_back(4'h8);
    instr(2'h1);
    cyc(3);
    cpu_i_mask <= 1'b0;
    exp_vec.push_back(4'h1);
    instr(2'h0);
    cyc(3);
    irq_en <= 8'hEF;
    irq(8'h10);
    instr(2'h0);
    cyc(3);
    flush();
    // random request and enable patterns
    repeat (4)
    begin
      pend = 8'($random(seed));
      en = 8'($random(seed));
      irq_en <= en;
      wdis <= 1'($random(seed));
      break_state <= 1'($random(seed));
      irq(pend);
      check(watchdog_run, 8'(!wdis));
      repeat (9)
      begin
        v = lowest(pend & en);
        if (v < 4'h8)
        begin
          exp_vec.push_back(v);
          pend[v[2:0]] = 1'b0;
        end
        instr(2'h0);
        cyc(3);
      end
      flush();
    end
    irq_en <= 8'hFF;
    wdis <= 1'b0;
    break_state <= 1'b0;
    instr(2'h2);
    check(i_mask_clear, 8'h01);
    check(clk_ctl.cpu_clk_en, 8'h00);
    check(clk_ctl.periph_clk_en, 8'h01);
    check(watchdog_run, 8'h01);
    exp_vec.push_back(4'h6);
    cyc(1);
    irq(8'h40);
    wait_int(n);
    check(8'(n), 8'h01);
    cyc(2);
    check(clk_ctl.cpu_clk_en, 8'h01);
    // break ends wait, flag then gated by the clear enable
    instr(2'h2);
    cyc(1);
    exp_vec.push_back(4'h8);
    break_req <= 1'b1;
    wait_int(n);
    cyc(1);
    break_req <= 1'b0;
    cyc(3);
    rd(2'h0, 8'h01);
    break_state <= 1'b1;
    wr(2'h0, 8'($random(seed)) & 8'hFE);
    rd(2'h0, 8'h01);
    wr(2'h2, 8'($random(seed)) | 8'h80);
    rd(2'h2, 8'h80);
    wr(2'h0, 8'($random(seed)) & 8'hFE);
    rd(2'h0, 8'h00);
    wr(2'h2, 8'($random(seed)) & 8'h7F);
    break_state <= 1'b0;
    instr(2'h3);
    check({4'h0, clk_ctl}, 8'h00);
    check(sys_counter_clear, 8'h01);
    exp_vec.push_back(4'h3);
    cyc(1);
    irq(8'h08);
    wait_int(n);
    check(8'(n), 8'(STOP_REC + 1));
    cyc(2);
    wdis <= 1'b1;
    cyc(2);
    check(watchdog_run, 8'h00);
    wdis <= 1'b0;
    // each reset source alone, the watchdog one out of wait
    for (int i = 0; i < 6; i++)
    begin
      if (i == 1)
      begin
        instr(2'h2);
        cyc(1);
      end
      rsrc[i] <= 1'b1;
      cyc(5);
      check(system_reset, 8'h01);
      rsrc[i] <= 1'b0;
      cyc(6);
      check(clk_ctl.cpu_clk_en, 8'h01);
      if (i == 5)
      begin
        break_state <= 1'b1;
        rd(2'h1, 8'h02);
        break_state <= 1'b0;
      end
      rd(2'h1, 8'h40 >> i);
    end
    // unmapped data access is not a fetch
    unm_only <= 1'b1;
    cyc(4);
    unm_only <= 1'b0;
    cyc(2);
    rd(2'h1, 8'h00);
    check(stack_high_index, 8'h00);
    cyc(5);
    print_verdict();
  end
endmodule
